// ==== branch_predict_return_stack.sv ====
// Purpose: Flow-change timing and return prediction of the core pipeline
// Assumes: Issue stage presents one classified instruction per cycle
// Notes:   Stall counts are charged after issue; issue_ready holds issue
//          A stalled offer is ignored, so issue must hold it until ready
//
// Function
// - A program counter write redirects execution to the computed address.
// - Target not forwarded; jump happens when it reaches writeback.
// - A mispredicted branch costs four cycles.
// - Folded branch: zero cycles if correct, four if mispredicted.
// - Branch and jump: 1 predicted, 4 otherwise; calls never fold.
// - Return stack holds four entries; overflow overwrites the oldest.
// - Hardware counts valid entries; over/underflow cost only time.
// - Return with empty stack counts as not predicted.
// - Return timings: 1/4, unconditional 2/4, multiple-load 2/6.
// - Simple ALU ops take one cycle; result usable next instruction.
// - Simple ALU issue, result and flag latency are one cycle.
// - Flags from a flag-setting op are forwarded to a following branch.
`timescale 1ns/1ps
`default_nettype none
`include "flow_defines.svh"

module branch_predict_return_stack (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                issue_valid,
    input  wire flow_pkg::op_class_t issue_op,
    input  wire logic                issue_cond_none,
    input  wire logic                issue_predicted,
    input  wire logic                issue_folded,
    input  wire logic [31:0]         issue_return_addr,
    input  wire logic                exec_resolved,
    input  wire logic                exec_mispredict,
    input  wire logic                alu_flags_valid,
    input  wire logic [3:0]          alu_flags,
    input  wire logic                writeback_pc_write,
    input  wire logic [31:0]         writeback_pc_value,
    output logic                     issue_ready,
    output logic                     redirect_valid,
    output logic [31:0]              redirect_addr,
    output logic                     ras_predict_valid,
    output logic [31:0]              ras_predict_addr,
    output logic [`CHG_W-1:0]        last_charge,
    output logic [3:0]               branch_flags
);

    typedef enum logic [1:0] {
        st_issue,
        st_stall,
        st_wait_writeback
    } flow_state_t;

    typedef struct packed {
        flow_state_t         fsm;
        logic [`CHG_W-1:0]   stall_cnt;
        logic [`CHG_W-1:0]   charge;
        logic                redirect;
        logic [31:0]         redirect_addr;
        logic [3:0]          flags;
    } ctl_state_t;

    ctl_state_t state_reg;
    ctl_state_t state_next;

    ras_if ras ();

    return_stack u_stack (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .rs      (ras.stack)
    );

    // ------------------------------------------------------------------
    // Cost decode
    // ------------------------------------------------------------------
    function automatic logic [`CHG_W-1:0] op_cost(
        input flow_pkg::op_class_t op,
        input logic pred, input logic fold, input logic miss,
        input logic cnone, input logic ras_empty);
        logic hit;
        hit = pred && !miss;
        op_cost = `CHG_ALU;
        unique case (op)
            flow_pkg::op_flow_change_disp,
            flow_pkg::op_relative_jump: begin
                if (fold && hit) begin
                    op_cost = `CHG_FOLD_OK;
                end else if (hit) begin
                    op_cost = `CHG_PRED_OK;
                end else begin
                    op_cost = `CHG_MISPREDICT;
                end
            end
            flow_pkg::op_relative_call: begin
                // Folding is ignored for calls
                op_cost = hit ? `CHG_PRED_OK : `CHG_MISPREDICT;
            end
            flow_pkg::op_subroutine_exit,
            flow_pkg::op_mov_link_to_pc: begin
                if (ras_empty || !pred) begin
                    op_cost = `CHG_RET_UNPRED;
                end else if (cnone || op == flow_pkg::op_mov_link_to_pc) begin
                    // Unconditional returns pay one extra cycle even when right
                    op_cost = `CHG_RET_UNCOND_OK;
                end else if (miss) begin
                    op_cost = `CHG_MISPREDICT;
                end else begin
                    op_cost = `CHG_PRED_OK;
                end
            end
            flow_pkg::op_pop_multiple_pc,
            flow_pkg::op_load_multiple_pc: begin
                if (ras_empty || !pred) begin
                    op_cost = `CHG_RET_MULTI_NP;
                end else begin
                    op_cost = `CHG_RET_UNCOND_OK;
                end
            end
            flow_pkg::op_none, flow_pkg::op_alu,
            flow_pkg::op_pc_dest: op_cost = `CHG_ALU;
        endcase
    endfunction : op_cost

    function automatic logic is_return(input flow_pkg::op_class_t op);
        is_return = op == flow_pkg::op_subroutine_exit ||
                    op == flow_pkg::op_mov_link_to_pc ||
                    op == flow_pkg::op_pop_multiple_pc ||
                    op == flow_pkg::op_load_multiple_pc;
    endfunction : is_return

    logic ras_empty;
    logic take;
    logic [`CHG_W-1:0] cost;

    assign ras_empty = ras.count == '0;
    // Taking only in the issue state keeps a stall from being charged twice
    assign take      = issue_valid && state_reg.fsm == st_issue;
    assign cost      = op_cost(issue_op, issue_predicted, issue_folded,
                               exec_resolved && exec_mispredict,
                               issue_cond_none, ras_empty);

    // ------------------------------------------------------------------
    // Return stack traffic
    // ------------------------------------------------------------------
    assign ras.push = take &&
                      issue_op == flow_pkg::op_relative_call;
    assign ras.push_addr = issue_return_addr;
    // Only predicted returns consume an entry; a pop on empty is dropped
    assign ras.pop  = take && is_return(issue_op) && issue_predicted
                      && !ras_empty;

    // An empty stack leaves a return unpredicted rather than guessed
    assign ras_predict_valid = !ras_empty;
    assign ras_predict_addr  = ras.top_addr;

    // ------------------------------------------------------------------
    // Control
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.redirect = 1'b0;
        // Bypass keeps the flag path free of a stall
        if (alu_flags_valid) begin
            state_next.flags = alu_flags;
        end
        unique case (state_reg.fsm)
            st_issue: begin
                if (take) begin
                    state_next.charge = cost;
                    // A charge of one or less lets the next issue follow, except a PC write, which waits for writeback
                    if (issue_op == flow_pkg::op_pc_dest) begin
                        state_next.fsm = st_wait_writeback;
                    end else if (cost > `CHG_W'(1)) begin
                        state_next.stall_cnt = cost - `CHG_W'(2);
                        state_next.fsm = st_stall;
                    end
                end
            end
            st_stall: begin
                if (state_reg.stall_cnt == '0) begin
                    state_next.fsm = st_issue;
                end else begin
                    state_next.stall_cnt = state_reg.stall_cnt - `CHG_W'(1);
                end
            end
            st_wait_writeback: begin
                // No forwarding of the target: wait for writeback
                if (writeback_pc_write) begin
                    state_next.redirect      = 1'b1;
                    state_next.redirect_addr = writeback_pc_value;
                    state_next.fsm           = st_issue;
                end
            end
            default: begin
                // The spare state code recovers to issue
                state_next.fsm = st_issue;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '{fsm: st_issue, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign issue_ready    = state_reg.fsm == st_issue;
    assign redirect_valid = state_reg.redirect;
    assign redirect_addr  = state_reg.redirect_addr;
    assign last_charge    = state_reg.charge;
    assign branch_flags   = alu_flags_valid ? alu_flags : state_reg.flags;

endmodule : branch_predict_return_stack

`default_nettype wire

// ==== flow_chk_monitor.sv ====
// Purpose: Port-level timing checks of the flow-change block
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
`include "flow_defines.svh"

module flow_chk_monitor (
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic                issue_valid,
    input wire flow_pkg::op_class_t issue_op,
    input wire logic                issue_cond_none,
    input wire logic                issue_predicted,
    input wire logic                issue_folded,
    input wire logic [31:0]         issue_return_addr,
    input wire logic                exec_resolved,
    input wire logic                exec_mispredict,
    input wire logic                alu_flags_valid,
    input wire logic [3:0]          alu_flags,
    input wire logic                writeback_pc_write,
    input wire logic [31:0]         writeback_pc_value,
    input wire logic                issue_ready,
    input wire logic                redirect_valid,
    input wire logic [31:0]         redirect_addr,
    input wire logic                ras_predict_valid,
    input wire logic [31:0]         ras_predict_addr,
    input wire logic [`CHG_W-1:0]   last_charge,
    input wire logic [3:0]          branch_flags
);
    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    wire tk = issue_valid && issue_ready;
    wire miss = exec_resolved && exec_mispredict;
    // PC writes wait on writeback, so their stall is excluded here
    wire tk_np = tk && issue_op != flow_pkg::op_pc_dest;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_flag_fwd;
        alu_flags_valid |-> branch_flags == alu_flags;
    endproperty
    a_flag_fwd: assert property (p_flag_fwd)
        else $error("flags late");
    property p_stall2;
        (tk_np ##1 last_charge == 3'h2) |->
            !issue_ready ##1 issue_ready;
    endproperty
    a_stall2: assert property (p_stall2)
        else $error("stall not 2");
    property p_stall4;
        (tk_np ##1 last_charge == 3'h4) |->
            !issue_ready [*3] ##1 issue_ready;
    endproperty
    a_stall4: assert property (p_stall4)
        else $error("stall not 4");
    property p_stall6;
        (tk_np ##1 last_charge == 3'h6) |->
            !issue_ready [*5] ##1 issue_ready;
    endproperty
    a_stall6: assert property (p_stall6)
        else $error("stall not 6");
    property p_fold;
        tk && issue_op == flow_pkg::op_flow_change_disp && issue_folded
            && issue_predicted && !miss
            |=> last_charge == 3'h0 && issue_ready;
    endproperty
    a_fold: assert property (p_fold)
        else $error("fold not free");
    property p_call;
        tk && issue_op == flow_pkg::op_relative_call && issue_predicted
            && !miss |=> last_charge == 3'h1 && ras_predict_valid
            && ras_predict_addr == $past(issue_return_addr);
    endproperty
    a_call: assert property (p_call)
        else $error("call wrong");
    property p_empty;
        tk && issue_op == flow_pkg::op_subroutine_exit && !issue_cond_none
            && !ras_predict_valid |=> last_charge == 3'h4;
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty return");
    property p_alu;
        tk && issue_op == flow_pkg::op_alu
            |=> last_charge == 3'h1 && issue_ready;
    endproperty
    a_alu: assert property (p_alu)
        else $error("alu not 1");
    property p_redir;
        redirect_valid |-> ($past(writeback_pc_write)
            && redirect_addr == $past(writeback_pc_value))
            ##1 !redirect_valid;
    endproperty
    a_redir: assert property (p_redir)
        else $error("bad redirect");
endmodule : flow_chk_monitor

bind branch_predict_return_stack flow_chk_monitor u_mon (.*);

`default_nettype wire

// ==== flow_defines.svh ====
// Purpose: Shared constants of the flow-change timing block
// Assumes: Included by bare name from every design file but the package
// Notes:   Cycle figures are best-case pipeline charges
`ifndef FLOW_DEFINES_SVH
`define FLOW_DEFINES_SVH

`define RAS_DEPTH          4
`define RAS_PTR_W          2
`define RAS_CNT_W          3
`define CHG_W              3
`define CHG_MISPREDICT     3'h4
`define CHG_FOLD_OK        3'h0
`define CHG_PRED_OK        3'h1
`define CHG_RET_UNCOND_OK  3'h2
`define CHG_RET_UNPRED     3'h4
`define CHG_RET_MULTI_NP   3'h6
`define CHG_ALU            3'h1

`endif

// ==== flow_pkg.sv ====
// Purpose: Types of the flow-change timing block
// Assumes: flow_defines.svh holds the figures
// Notes:   Operation classes as seen at issue
package flow_pkg;

    typedef enum logic [3:0] {
        op_none,
        op_alu,
        op_flow_change_disp,
        op_relative_jump,
        op_relative_call,
        op_subroutine_exit,
        op_mov_link_to_pc,
        op_pop_multiple_pc,
        op_load_multiple_pc,
        op_pc_dest
    } op_class_t;

endpackage : flow_pkg

// ==== ras_if.sv ====
// Purpose: Carrier between the timing control and the return stack
// Assumes: Single clock domain
// Notes:   Push and pop are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "flow_defines.svh"

interface ras_if;
    logic                   push;
    logic                   pop;
    logic [31:0]            push_addr;
    logic [31:0]            top_addr;
    logic [`RAS_CNT_W-1:0]  count;

    modport ctrl (output push, output pop, output push_addr,
                  input top_addr, input count);
    modport stack (input push, input pop, input push_addr,
                   output top_addr, output count);
endinterface : ras_if

`default_nettype wire

// ==== return_stack.sv ====
// Purpose: Four-entry return address stack
// Assumes: Push and pop never asserted together by the controller
// Notes:   Oldest entry is lost on overflow; top comes from a register
`timescale 1ns/1ps
`default_nettype none
`include "flow_defines.svh"

module return_stack (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    ras_if.stack      rs
);

    typedef struct packed {
        logic [`RAS_DEPTH-1:0][31:0]  mem;
        logic [`RAS_PTR_W-1:0]        top;
        logic [`RAS_CNT_W-1:0]        count;
        logic [31:0]                  top_addr;
    } ras_state_t;

    ras_state_t state_reg;
    ras_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (rs.push) begin
            // Ring write: a full stack simply overwrites its oldest slot
            state_next.top = state_reg.top + `RAS_PTR_W'(1);
            state_next.mem[state_next.top] = rs.push_addr;
            if (state_reg.count != `RAS_CNT_W'(`RAS_DEPTH)) begin
                state_next.count = state_reg.count + `RAS_CNT_W'(1);
            end
        end else if (rs.pop && state_reg.count != '0) begin
            state_next.top   = state_reg.top - `RAS_PTR_W'(1);
            state_next.count = state_reg.count - `RAS_CNT_W'(1);
        end
        state_next.top_addr = state_next.mem[state_next.top];
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rs.top_addr = state_reg.top_addr;
    assign rs.count    = state_reg.count;

endmodule : return_stack

`default_nettype wire

// ==== test_branch_predict_return_stack.sv ====
// Purpose: Directed scenarios for the flow-change timing block
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Stall length is counted from issue_ready
`timescale 1ns/1ps
`default_nettype none
`include "flow_defines.svh"

module test_branch_predict_return_stack;
    logic ref_clk = 1'b0, sys_rst = 1'b1, issue_valid = 1'b0;
    logic issue_cond_none = 1'b0, issue_predicted = 1'b0, issue_folded = 1'b0;
    logic exec_resolved = 1'b0, exec_mispredict = 1'b0;
    logic writeback_pc_write = 1'b0;
    logic alu_flags_valid = 1'b0, issue_ready, redirect_valid, ras_predict_valid;
    flow_pkg::op_class_t issue_op = flow_pkg::op_none;
    logic [31:0] issue_return_addr = 32'h0, writeback_pc_value = 32'h0;
    logic [31:0] redirect_addr, ras_predict_addr;
    logic [3:0] alu_flags = 4'h0, branch_flags;
    logic [`CHG_W-1:0] last_charge;
    int bad_count = 0, num_checks = 0;

    branch_predict_return_stack u_dut (.*);

    always #12.5 ref_clk = ~ref_clk;

    // -------------------------------------------------
    // Shared tasks
    // -------------------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
        end
    endtask : chk

    task automatic issue(flow_pkg::op_class_t op, logic p, f, m, c, int e);
        int n;
        n = 0;
        // An idle edge between offers keeps each strobe to one change a step
        @(posedge ref_clk);
        #2 issue_op = op;
        {issue_predicted, issue_folded, exec_resolved, exec_mispredict,
         issue_cond_none, issue_valid} = {p, f, 1'b1, m, c, 1'b1};
        @(posedge ref_clk);
        #2 issue_valid = 1'b0;
        chk("charge", e, 32'(last_charge));
        while (!issue_ready && n < 9) begin
            @(posedge ref_clk);
            #2 n++;
        end
        chk("stall", (e > 1) ? e - 1 : 0, n);
    endtask : issue

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    task automatic t_alu;
        alu_flags = 4'hA;
        alu_flags_valid = 1'b1;
        #1 chk("fwd", 32'hA, 32'(branch_flags));
        issue(flow_pkg::op_alu, 0, 0, 0, 0, 1);
        alu_flags_valid = 1'b0;
        alu_flags = 4'h5;
        #1 chk("held", 32'hA, 32'(branch_flags));
        issue(flow_pkg::op_flow_change_disp, 1, 0, 0, 0, 1);
    endtask : t_alu

    task automatic t_branch;
        flow_pkg::op_class_t op;
        for (int k = 0; k < 2; k++) begin
            op = k ? flow_pkg::op_relative_jump : flow_pkg::op_flow_change_disp;
            issue(op, 1, 0, 0, 0, 1);
            issue(op, 1, 0, 1, 0, `CHG_MISPREDICT);
            issue(op, 1, 1, 0, 0, `CHG_FOLD_OK);
            issue(op, 1, 1, 1, 0, 4);
            issue(op, 0, 0, 0, 0, 4);
        end
        // A call offered as folded must still cost one cycle
        issue(flow_pkg::op_relative_call, 1, 1, 0, 0, 1);
        issue(flow_pkg::op_relative_call, 1, 0, 1, 0, 4);
    endtask : t_branch

    task automatic t_ras;
        for (int k = 0; k < 5; k++) begin
            issue_return_addr = 32'h100 + 32'(k);
            issue(flow_pkg::op_relative_call, 1, 0, 0, 0, 1);
        end
        // Two calls from t_branch are still stacked, so the last three pushes overflow: oldest entries lost, four remain
        for (int k = 4; k > 0; k--) begin
            chk("top", 32'h100 + 32'(k), ras_predict_addr);
            issue(flow_pkg::op_subroutine_exit, 1, 0, 0, 0, 1);
        end
        chk("empty", 0, 32'(ras_predict_valid));
        issue(flow_pkg::op_subroutine_exit, 1, 0, 0, 0, 4);
    endtask : t_ras

    task automatic t_ret;
        flow_pkg::op_class_t ops[4] = '{flow_pkg::op_subroutine_exit,
            flow_pkg::op_mov_link_to_pc, flow_pkg::op_pop_multiple_pc,
            flow_pkg::op_load_multiple_pc};
        for (int k = 0; k < 4; k++) begin
            issue(flow_pkg::op_relative_call, 1, 0, 0, 0, 1);
            issue(ops[k], 1, 0, 0, 1, `CHG_RET_UNCOND_OK);
            issue(ops[k], 1, 0, 0, 1, (k > 1) ? 6 : 4);
        end
    endtask : t_ret

    task automatic t_pc;
        writeback_pc_write = 1'b1;
        @(posedge ref_clk);
        #2 writeback_pc_write = 1'b0;
        chk("idle writeback", 0, 32'(redirect_valid));
        issue_op = flow_pkg::op_pc_dest;
        issue_valid = 1'b1;
        @(posedge ref_clk);
        #2 issue_valid = 1'b0;
        chk("early", 0, 32'(redirect_valid));
        {writeback_pc_write, writeback_pc_value} = {1'b1, 32'h8C40};
        @(posedge ref_clk);
        #2 writeback_pc_write = 1'b0;
        chk("jump", 1, 32'(redirect_valid));
        chk("target", 32'h8C40, redirect_addr);
    endtask : t_pc

    initial begin
        repeat (20) @(posedge ref_clk);
        #2 sys_rst = 1'b0;
        t_alu();
        t_branch();
        t_ras();
        t_ret();
        t_pc();
        end_of_test();
    end

    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule : test_branch_predict_return_stack

`default_nettype wire
